// [design/smpc_pin_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module smpc_pin_ctrl
	import smpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_rom_data_in,
	output logic serial_rom_data_out,
	output logic serial_rom_data_oe,
	output logic serial_rom_clock,
	input wire logic rom_clock_req,
	input wire logic rom_data_req,
	input wire logic rom_data_oe_req,
	output logic rom_data_rx,
	input wire logic scan_shift_en_in,
	output logic scan_shift_en_out,
	output logic scan_shift_en_oe,
	input wire logic mfg_test_mode,
	output logic scan_shift_en_core,
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe,
	input wire logic [7:0] gpio_out_ctrl,
	input wire logic [7:0] gpio_oe_ctrl,
	output logic [7:0] gpio_rx,
	input wire logic power_saving_strap,
	input wire logic substate_or_status_select,
	input wire logic protocol_select_strap,
	input wire logic debug_enable_strap,
	output logic straps_valid,
	output logic config_rom_enable,
	output logic power_save_enable,
	output logic l1ss_enable,
	output logic port_status_mode,
	output logic mgmt_protocol_smbus,
	output logic [2:0] mgmt_addr_low,
	output logic debug_mode_active,
	output logic [4:0] debug_select,
	input wire logic [2:0] clock_request_n_in,
	output logic [2:0] clock_request_n_out,
	output logic [2:0] clock_request_n_oe,
	input wire logic [2:0] l1ss_clkreq_n_req,
	input wire logic [2:0] l1ss_clkreq_oe_req,
	input wire logic [2:0] port_state,
	output logic [2:0] clock_request_n_rx,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic test_reset_n,
	output logic tdo,
	output logic tdo_oe,
	output logic [IR_W-1:0] tap_instruction
);
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic [2:0] settle_reg, settle_next;
	logic captured_reg, captured_next;
	logic rom_en_reg, rom_en_next, pwr_reg, pwr_next, sel_reg, sel_next;
	logic smb_reg, smb_next, dbg_reg, dbg_next;
	logic [2:0] addr_reg, addr_next;
	logic rom_do_reg, rom_do_next, rom_oe_reg, rom_oe_next, rom_clk_reg, rom_clk_next;
	logic [7:0] gpo_reg, gpo_next, gpoe_reg, gpoe_next;
	logic [4:0] dsel_reg, dsel_next;
	logic [2:0] ck_out_reg, ck_out_next, ck_oe_reg, ck_oe_next;
	smpc_tap_state_t tap_reg, tap_next;
	logic [IR_W-1:0] ir_reg, ir_next, irsh_reg, irsh_next;
	logic byp_reg, byp_next, tdo_reg, tdo_next, tdoe_reg, tdoe_next;
	logic tck_prev_reg, tck_rise, tck_fall, trst_act;

	assign pin_raw = {test_reset_n, tdi, tms, tck, clock_request_n_in, debug_enable_strap,
		protocol_select_strap, substate_or_status_select, power_saving_strap, gpio_in,
		scan_shift_en_in, serial_rom_data_in};

	////////////////////////////////////////////////////////////////////////////////
	// pin synchroniser, a bit changes once stages two and three agree
	always_comb begin
		filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= PIN_RST;
			s2_reg <= PIN_RST;
			s3_reg <= PIN_RST;
			filt_reg <= PIN_RST;
		end else begin
			s1_reg <= pin_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// strap capture
	always_comb begin
		settle_next = settle_reg;
		captured_next = captured_reg;
		rom_en_next = rom_en_reg;
		pwr_next = pwr_reg;
		sel_next = sel_reg;
		smb_next = smb_reg;
		dbg_next = dbg_reg;
		addr_next = addr_reg;
		if (!captured_reg) begin
			if (settle_reg == STRAP_SETTLE_CYCLES) begin
				captured_next = 1'b1;
				rom_en_next = filt_reg[P_ROM];
				pwr_next = filt_reg[P_PWR];
				sel_next = filt_reg[P_SEL];
				smb_next = filt_reg[P_SMB];
				dbg_next = ~filt_reg[P_DBG];
				addr_next = filt_reg[P_GPIO+7:P_GPIO+5];
			end else begin
				settle_next = settle_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			settle_reg <= 3'h0;
			captured_reg <= 1'b0;
			rom_en_reg <= PIN_RST[P_ROM];
			pwr_reg <= PIN_RST[P_PWR];
			sel_reg <= PIN_RST[P_SEL];
			smb_reg <= PIN_RST[P_SMB];
			dbg_reg <= ~PIN_RST[P_DBG];
			addr_reg <= 3'h0;
		end else begin
			settle_reg <= settle_next;
			captured_reg <= captured_next;
			rom_en_reg <= rom_en_next;
			pwr_reg <= pwr_next;
			sel_reg <= sel_next;
			smb_reg <= smb_next;
			dbg_reg <= dbg_next;
			addr_reg <= addr_next;
		end
	end

	assign straps_valid = captured_reg;
	assign config_rom_enable = rom_en_reg;
	assign power_save_enable = pwr_reg;
	assign l1ss_enable = captured_reg & ~sel_reg;
	assign port_status_mode = captured_reg & sel_reg;
	assign mgmt_protocol_smbus = smb_reg;
	assign mgmt_addr_low = addr_reg;
	assign debug_mode_active = captured_reg & dbg_reg;

	////////////////////////////////////////////////////////////////////////////////
	// pin drivers
	always_comb begin
		rom_clk_next = captured_reg & rom_en_reg & rom_clock_req;
		rom_do_next = rom_data_req;
		rom_oe_next = captured_reg & rom_en_reg & rom_data_oe_req;
		gpo_next = gpio_out_ctrl;
		gpoe_next = gpio_oe_ctrl;
		dsel_next = debug_mode_active ? filt_reg[P_GPIO+4:P_GPIO] : 5'h00;
		if (port_status_mode) begin
			ck_out_next = port_state;
			ck_oe_next = CLKREQ_ALL_DRIVEN;
		end else if (l1ss_enable) begin
			ck_out_next = l1ss_clkreq_n_req;
			ck_oe_next = l1ss_clkreq_oe_req;
		end else begin
			ck_out_next = 3'h7;
			ck_oe_next = 3'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rom_clk_reg <= 1'b0;
			rom_do_reg <= 1'b0;
			rom_oe_reg <= 1'b0;
			gpo_reg <= 8'h00;
			gpoe_reg <= 8'h00;
			dsel_reg <= 5'h00;
			ck_out_reg <= 3'h7;
			ck_oe_reg <= 3'h0;
		end else begin
			rom_clk_reg <= rom_clk_next;
			rom_do_reg <= rom_do_next;
			rom_oe_reg <= rom_oe_next;
			gpo_reg <= gpo_next;
			gpoe_reg <= gpoe_next;
			dsel_reg <= dsel_next;
			ck_out_reg <= ck_out_next;
			ck_oe_reg <= ck_oe_next;
		end
	end

	assign serial_rom_clock = rom_clk_reg;
	assign serial_rom_data_out = rom_do_reg;
	assign serial_rom_data_oe = rom_oe_reg;
	assign rom_data_rx = filt_reg[P_ROM];
	assign gpio_out = gpo_reg;
	assign gpio_oe = gpoe_reg;
	assign gpio_rx = filt_reg[P_GPIO+7:P_GPIO];
	assign debug_select = dsel_reg;
	assign clock_request_n_out = ck_out_reg;
	assign clock_request_n_oe = ck_oe_reg;
	assign clock_request_n_rx = filt_reg[P_CLKREQ+2:P_CLKREQ];
	assign scan_shift_en_out = 1'b0;
	assign scan_shift_en_oe = ~mfg_test_mode;
	assign scan_shift_en_core = mfg_test_mode & filt_reg[P_SCAN];

	////////////////////////////////////////////////////////////////////////////////
	// test access port, tck edges from the filtered pin
	assign tck_rise = filt_reg[P_TCK] & ~tck_prev_reg;
	assign tck_fall = ~filt_reg[P_TCK] & tck_prev_reg;
	assign trst_act = ~filt_reg[P_TRST];

	always_comb begin
		tap_next = tap_reg;
		ir_next = ir_reg;
		irsh_next = irsh_reg;
		byp_next = byp_reg;
		tdo_next = tdo_reg;
		tdoe_next = tdoe_reg;
		if (trst_act) begin
			tap_next = TAP_RESET;
			ir_next = IR_RESET;
			tdoe_next = 1'b0;
		end else if (tck_rise) begin
			unique case (tap_reg)
				TAP_CAP_DR: byp_next = 1'b0;
				TAP_SHIFT_DR: byp_next = filt_reg[P_TDI];
				TAP_CAP_IR: irsh_next = IR_CAPTURE;
				TAP_SHIFT_IR: irsh_next = {filt_reg[P_TDI], irsh_reg[IR_W-1:1]};
				TAP_UPD_IR: ir_next = irsh_reg;
				TAP_RESET: ir_next = IR_RESET;
				default: ir_next = ir_reg;
			endcase
			unique case (tap_reg)
				TAP_RESET: tap_next = filt_reg[P_TMS] ? TAP_RESET : TAP_IDLE;
				TAP_IDLE: tap_next = filt_reg[P_TMS] ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: tap_next = filt_reg[P_TMS] ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: tap_next = filt_reg[P_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
				TAP_SHIFT_DR: tap_next = filt_reg[P_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
				TAP_EXIT1_DR: tap_next = filt_reg[P_TMS] ? TAP_UPD_DR : TAP_PAUSE_DR;
				TAP_PAUSE_DR: tap_next = filt_reg[P_TMS] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
				TAP_EXIT2_DR: tap_next = filt_reg[P_TMS] ? TAP_UPD_DR : TAP_SHIFT_DR;
				TAP_UPD_DR: tap_next = filt_reg[P_TMS] ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR: tap_next = filt_reg[P_TMS] ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: tap_next = filt_reg[P_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
				TAP_SHIFT_IR: tap_next = filt_reg[P_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
				TAP_EXIT1_IR: tap_next = filt_reg[P_TMS] ? TAP_UPD_IR : TAP_PAUSE_IR;
				TAP_PAUSE_IR: tap_next = filt_reg[P_TMS] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
				TAP_EXIT2_IR: tap_next = filt_reg[P_TMS] ? TAP_UPD_IR : TAP_SHIFT_IR;
				TAP_UPD_IR: tap_next = filt_reg[P_TMS] ? TAP_SEL_DR : TAP_IDLE;
			endcase
		end else if (tck_fall) begin
			tdoe_next = (tap_reg == TAP_SHIFT_DR) || (tap_reg == TAP_SHIFT_IR);
			tdo_next = (tap_reg == TAP_SHIFT_IR) ? irsh_reg[0] : byp_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tck_prev_reg <= 1'b0;
			tap_reg <= TAP_RESET;
			ir_reg <= IR_RESET;
			irsh_reg <= IR_CAPTURE;
			byp_reg <= 1'b0;
			tdo_reg <= 1'b0;
			tdoe_reg <= 1'b0;
		end else begin
			tck_prev_reg <= filt_reg[P_TCK];
			tap_reg <= tap_next;
			ir_reg <= ir_next;
			irsh_reg <= irsh_next;
			byp_reg <= byp_next;
			tdo_reg <= tdo_next;
			tdoe_reg <= tdoe_next;
		end
	end

	assign tdo = tdo_reg;
	assign tdo_oe = tdoe_reg;
	assign tap_instruction = ir_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_rom_strap_off: assert property (@(posedge clk) disable iff (rst)
		captured_reg && !rom_en_reg |=> !serial_rom_data_oe && !serial_rom_clock)
		else $error("rom pins active while rom disabled");
	a_rom_clock_run: assert property (@(posedge clk) disable iff (rst)
		captured_reg && rom_en_reg && rom_clock_req |=> serial_rom_clock)
		else $error("rom clock not forwarded");
	a_scan_low: assert property (@(posedge clk) disable iff (rst)
		!mfg_test_mode |-> scan_shift_en_oe && !scan_shift_en_out && !scan_shift_en_core)
		else $error("scan enable not held low");
	a_gpio_dir: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> gpio_oe == $past(gpio_oe_ctrl))
		else $error("gpio direction mismatch");
	a_addr_strap: assert property (@(posedge clk) disable iff (rst)
		$rose(captured_reg) |-> mgmt_addr_low == $past(filt_reg[P_GPIO+7:P_GPIO+5]))
		else $error("management address not from gpio");
	a_debug_code: assert property (@(posedge clk) disable iff (rst)
		!debug_mode_active |=> debug_select == 5'h00)
		else $error("debug select outside debug mode");
	a_power_save: assert property (@(posedge clk) disable iff (rst)
		$rose(captured_reg) |-> power_save_enable == $past(filt_reg[P_PWR]))
		else $error("power saving strap mismatch");
	a_mode_excl: assert property (@(posedge clk) disable iff (rst)
		captured_reg |-> l1ss_enable != port_status_mode)
		else $error("substate and status both or neither");
	a_proto_sel: assert property (@(posedge clk) disable iff (rst)
		$rose(captured_reg) |-> mgmt_protocol_smbus == $past(filt_reg[P_SMB]))
		else $error("protocol strap mismatch");
	a_tap_shift: assert property (@(posedge clk) disable iff (rst)
		!trst_act && tck_fall && tap_reg == TAP_SHIFT_DR |=> tdo_oe && tdo == $past(byp_reg))
		else $error("tdo not driven in shift");
	a_tap_step: assert property (@(posedge clk) disable iff (rst)
		!trst_act && tck_rise && tap_reg == TAP_RESET && !filt_reg[P_TMS] |=> tap_reg == TAP_IDLE)
		else $error("tap did not leave reset");
	a_tap_trst: assert property (@(posedge clk) disable iff (rst)
		trst_act |=> tap_reg == TAP_RESET && ir_reg == IR_RESET)
		else $error("test reset ignored");
	a_status_out: assert property (@(posedge clk) disable iff (rst)
		port_status_mode |=> clock_request_n_oe == 3'h7 && clock_request_n_out == $past(port_state))
		else $error("port status not driven");
	a_strap_hold: assert property (@(posedge clk) disable iff (rst)
		captured_reg |=> $stable(rom_en_reg) && $stable(sel_reg) && $stable(addr_reg))
		else $error("strap changed after capture");
endmodule // smpc_pin_ctrl
`default_nettype wire

// [design/smpc_pkg.sv]
`default_nettype none
package smpc_pkg;
	// positions inside the synchronised pin vector
	localparam int P_ROM = 0;
	localparam int P_SCAN = 1;
	localparam int P_GPIO = 2;
	localparam int P_PWR = 10;
	localparam int P_SEL = 11;
	localparam int P_SMB = 12;
	localparam int P_DBG = 13;
	localparam int P_CLKREQ = 14;
	localparam int P_TCK = 17;
	localparam int P_TMS = 18;
	localparam int P_TDI = 19;
	localparam int P_TRST = 20;
	localparam int PIN_W = 21;
	// filter reset values: rom data, power saving and debug enable bits high, all others low
	localparam logic [PIN_W-1:0] PIN_RST = 21'h002401;
	// sync chain plus filter before straps are trusted
	localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET = 4'hf;
	localparam logic [2:0] CLKREQ_ALL_DRIVEN = 3'h7;

	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h3,
		TAP_CAP_DR = 4'h2,
		TAP_SHIFT_DR = 4'h6,
		TAP_EXIT1_DR = 4'h7,
		TAP_UPD_DR = 4'h5,
		TAP_PAUSE_DR = 4'h4,
		TAP_EXIT2_DR = 4'hc,
		TAP_SEL_IR = 4'hd,
		TAP_CAP_IR = 4'hf,
		TAP_SHIFT_IR = 4'he,
		TAP_EXIT1_IR = 4'ha,
		TAP_PAUSE_IR = 4'hb,
		TAP_EXIT2_IR = 4'h9,
		TAP_UPD_IR = 4'h8
	} smpc_tap_state_t;
endpackage
`default_nettype wire

// [verif/smpc_board.sv]
`timescale 1ns/1ps
`default_nettype none
module smpc_board (
	input wire logic straps_valid,
	input wire logic rom_strap,
	input wire logic rom_drv,
	input wire logic rom_reply,
	input wire logic serial_rom_data_oe,
	input wire logic serial_rom_data_out,
	input wire logic debug_req,
	input wire logic [7:0] gpio_board,
	input wire logic [7:0] gpio_out,
	input wire logic [7:0] gpio_oe,
	input wire logic [2:0] clock_request_n_out,
	input wire logic [2:0] clock_request_n_oe,
	output logic serial_rom_data_in,
	output logic [7:0] gpio_in,
	output logic debug_enable_strap,
	output logic [2:0] clock_request_n_in
);
	////////////////////////////////////////////////////////////////
	// strap then rom data
	// pull-up holds the line high when nobody drives it
	assign serial_rom_data_in = serial_rom_data_oe ? serial_rom_data_out :
		(!straps_valid ? rom_strap : (rom_drv ? rom_reply : 1'b1));
	assign debug_enable_strap = ~debug_req;
	// board side of gpio pins
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_board);
	// clock request pins pulled high
	assign clock_request_n_in = (clock_request_n_oe & clock_request_n_out) | ~clock_request_n_oe;
endmodule // smpc_board
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
	import smpc_pkg::*;
;
	logic clk, rst, rom_clock_req, rom_data_req, rom_data_oe_req, scan_shift_en_in, mfg_test_mode;
	logic power_saving_strap, substate_or_status_select, protocol_select_strap;
	logic tck, tms, tdi, test_reset_n, rom_strap, rom_drv, rom_reply, debug_req;
	logic [7:0] gpio_out_ctrl, gpio_oe_ctrl, gpio_board, gpio_out, gpio_oe, gpio_rx;
	logic [2:0] l1ss_clkreq_n_req, l1ss_clkreq_oe_req, port_state, mgmt_addr_low;
	logic [2:0] clock_request_n_out, clock_request_n_oe, clock_request_n_rx;
	wire logic serial_rom_data_in, debug_enable_strap;
	wire logic [7:0] gpio_in;
	wire logic [2:0] clock_request_n_in;
	logic serial_rom_data_out, serial_rom_data_oe, serial_rom_clock, rom_data_rx;
	logic scan_shift_en_out, scan_shift_en_oe, scan_shift_en_core, straps_valid;
	logic config_rom_enable, power_save_enable, l1ss_enable, port_status_mode;
	logic mgmt_protocol_smbus, debug_mode_active, tdo, tdo_oe;
	logic [4:0] debug_select;
	logic [IR_W-1:0] tap_instruction;
	int n_fail, check_count;

	smpc_pin_ctrl u_dut (.*);
	smpc_board u_board (.*);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic do_reset;
		rst = 1'b1;
		cyc(3);
		chk("valid", straps_valid, 8'h0);
		rst = 1'b0;
		for (int i = 0; i < 12 && straps_valid !== 1'b1; i++) cyc(1);
		if (straps_valid !== 1'b1) begin
			n_fail++;
			close_out;
		end
	endtask

	task automatic jt(input logic m, input logic d);
		tms = m;
		tdi = d;
		tck = 1'b1;
		cyc(8);
		tck = 1'b0;
		cyc(8);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_straps_a;
		power_saving_strap = 1'b0;
		substate_or_status_select = 1'b1;
		protocol_select_strap = 1'b1;
		debug_req = 1'b1;
		rom_strap = 1'b0;
		gpio_board = 8'hb3;
		do_reset;
		chk("rom_en", config_rom_enable, 8'h0);
		chk("pwr", power_save_enable, 8'h0);
		chk("status", port_status_mode, 8'h1);
		chk("l1ss", l1ss_enable, 8'h0);
		chk("smbus", mgmt_protocol_smbus, 8'h1);
		chk("addr", mgmt_addr_low, 8'h5);
		chk("dbg", debug_mode_active, 8'h1);
		cyc(2);
		chk("dsel", debug_select, 8'h13);
		rom_data_oe_req = 1'b1;
		rom_clock_req = 1'b1;
		port_state = 3'h5;
		power_saving_strap = 1'b1;
		substate_or_status_select = 1'b0;
		protocol_select_strap = 1'b0;
		debug_req = 1'b0;
		gpio_board = 8'h4c;
		cyc(8);
		chk("rom_oe", serial_rom_data_oe, 8'h0);
		chk("rom_clk", serial_rom_clock, 8'h0);
		chk("pwr", power_save_enable, 8'h0);
		chk("status", port_status_mode, 8'h1);
		chk("smbus", mgmt_protocol_smbus, 8'h1);
		chk("addr", mgmt_addr_low, 8'h5);
		chk("dbg", debug_mode_active, 8'h1);
		chk("dsel", debug_select, 8'h0c);
		chk("creq_out", clock_request_n_out, 8'h5);
		chk("creq_oe", clock_request_n_oe, 8'h7);
		rom_data_oe_req = 1'b0;
		rom_clock_req = 1'b0;
	endtask

	task automatic t_scan;
		mfg_test_mode = 1'b0;
		scan_shift_en_in = 1'b1;
		cyc(6);
		chk("scan_oe", scan_shift_en_oe, 8'h1);
		chk("scan_out", scan_shift_en_out, 8'h0);
		chk("scan_core", scan_shift_en_core, 8'h0);
		mfg_test_mode = 1'b1;
		cyc(6);
		chk("scan_oe", scan_shift_en_oe, 8'h0);
		chk("scan_core", scan_shift_en_core, 8'h1);
		mfg_test_mode = 1'b0;
	endtask

	task automatic t_gpio;
		gpio_board = 8'h3c;
		gpio_oe_ctrl = 8'h0f;
		gpio_out_ctrl = 8'ha5;
		cyc(1);
		chk("gpio_oe", gpio_oe, 8'h0f);
		chk("gpio_out", gpio_out, 8'ha5);
		cyc(6);
		chk("gpio_rx", gpio_rx, 8'h35);
		gpio_oe_ctrl = 8'h00;
		cyc(7);
		chk("gpio_rx", gpio_rx, 8'h3c);
	endtask

	task automatic t_straps_b;
		rom_strap = 1'b1;
		gpio_board = 8'h5f;
		do_reset;
		chk("rom_en", config_rom_enable, 8'h1);
		chk("pwr", power_save_enable, 8'h1);
		chk("l1ss", l1ss_enable, 8'h1);
		chk("status", port_status_mode, 8'h0);
		chk("smbus", mgmt_protocol_smbus, 8'h0);
		chk("addr", mgmt_addr_low, 8'h2);
		chk("dbg", debug_mode_active, 8'h0);
		l1ss_clkreq_n_req = 3'h2;
		l1ss_clkreq_oe_req = 3'h6;
		cyc(2);
		chk("dsel", debug_select, 8'h0);
		chk("creq_out", clock_request_n_out, 8'h2);
		chk("creq_oe", clock_request_n_oe, 8'h6);
		cyc(6);
		chk("creq_rx", clock_request_n_rx, 8'h3);
		rom_clock_req = 1'b1;
		rom_data_oe_req = 1'b1;
		rom_data_req = 1'b1;
		cyc(2);
		chk("rom_clk", serial_rom_clock, 8'h1);
		chk("rom_oe", serial_rom_data_oe, 8'h1);
		chk("rom_out", serial_rom_data_out, 8'h1);
		cyc(5);
		chk("rom_rx", rom_data_rx, 8'h1);
		rom_data_oe_req = 1'b0;
		rom_drv = 1'b1;
		rom_reply = 1'b0;
		cyc(7);
		chk("rom_rx", rom_data_rx, 8'h0);
		rom_drv = 1'b0;
		rom_clock_req = 1'b0;
	endtask

	task automatic t_jtag;
		test_reset_n = 1'b0;
		cyc(6);
		chk("ir", tap_instruction, 8'h0f);
		test_reset_n = 1'b1;
		cyc(6);
		jt(1'b0, 1'b0);
		jt(1'b1, 1'b0);
		jt(1'b1, 1'b0);
		jt(1'b0, 1'b0);
		jt(1'b0, 1'b0);
		chk("tdo_oe", tdo_oe, 8'h1);
		chk("tdo", tdo, 8'h1);
		jt(1'b0, 1'b1);
		chk("tdo", tdo, 8'h0);
		jt(1'b0, 1'b1);
		chk("tdo", tdo, 8'h0);
		jt(1'b0, 1'b0);
		chk("tdo", tdo, 8'h0);
		jt(1'b1, 1'b0);
		chk("tdo_oe", tdo_oe, 8'h0);
		jt(1'b1, 1'b0);
		jt(1'b0, 1'b0);
		chk("ir", tap_instruction, 8'h3);
		jt(1'b1, 1'b0);
		jt(1'b0, 1'b0);
		jt(1'b0, 1'b0);
		chk("tdo", tdo, 8'h0);
		jt(1'b0, 1'b1);
		chk("tdo", tdo, 8'h1);
		jt(1'b1, 1'b0);
		jt(1'b0, 1'b0);
		chk("tdo_oe", tdo_oe, 8'h0);
		jt(1'b1, 1'b0);
		jt(1'b0, 1'b0);
		chk("tdo_oe", tdo_oe, 8'h1);
		chk("tdo", tdo, 8'h0);
		jt(1'b1, 1'b0);
		jt(1'b1, 1'b0);
		test_reset_n = 1'b0;
		cyc(6);
		chk("ir", tap_instruction, 8'h0f);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{rst, rom_clock_req, rom_data_req, rom_data_oe_req, scan_shift_en_in} = 5'h10;
		{mfg_test_mode, tck, tms, tdi, test_reset_n, rom_drv, rom_reply} = 7'h00;
		{power_saving_strap, substate_or_status_select, protocol_select_strap} = 3'h4;
		{rom_strap, debug_req} = 2'h2;
		{gpio_out_ctrl, gpio_oe_ctrl, gpio_board} = 24'h0;
		{l1ss_clkreq_n_req, l1ss_clkreq_oe_req, port_state} = 9'h1c0;
		n_fail = 0;
		check_count = 0;
		t_straps_a;
		t_scan;
		t_gpio;
		t_straps_b;
		t_jtag;
		close_out;
	end
endmodule // tb
`default_nettype wire
